// ---- ddsl_core.v ----
// Serial frame receiver, data buffers and DAC registers of the dual DAC load control.
`timescale 1ns/100ps
`default_nettype none
`include "ddsl_map.vh"
module ddsl_core (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_sync_n,
    input  wire        i_sclk,
    input  wire        i_sdin,
    output wire [15:0] o_dac_a,
    output wire [15:0] o_dac_b,
    output wire [1:0]  o_mode_a,
    output wire [1:0]  o_mode_b,
    output wire        o_update_a,
    output wire        o_update_b,
    output wire        o_frame_done
);
    wire sync_n_s;
    wire sclk_s;
    wire sdin_s;

    // Frame-select idles high, so its synchroniser resets high to avoid a false frame start.
    ddsl_sync #(.RESET_VAL(1'b1)) u_sync_fs (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_sync_n),
        .o_sync  (sync_n_s)
    );
    ddsl_sync #(.RESET_VAL(1'b0)) u_sync_ck (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_sclk),
        .o_sync  (sclk_s)
    );
    ddsl_sync #(.RESET_VAL(1'b0)) u_sync_dt (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_sdin),
        .o_sync  (sdin_s)
    );

    // Receiver state.
    reg        sclk_prev_q;
    reg [23:0] shift_q;
    reg [23:0] shift_d;
    reg [4:0]  count_q;
    reg [4:0]  count_d;
    reg        armed_q;
    reg        armed_d;
    reg        done_q;
    reg        done_d;
    // Data buffers and their power-down codes.
    reg [15:0] buf_a_q;
    reg [15:0] buf_a_d;
    reg [15:0] buf_b_q;
    reg [15:0] buf_b_d;
    reg [1:0]  bpd_a_q;
    reg [1:0]  bpd_a_d;
    reg [1:0]  bpd_b_q;
    reg [1:0]  bpd_b_d;
    // DAC registers, channel modes and load pulses.
    reg [15:0] dac_a_q;
    reg [15:0] dac_a_d;
    reg [15:0] dac_b_q;
    reg [15:0] dac_b_d;
    reg [1:0]  mode_a_q;
    reg [1:0]  mode_a_d;
    reg [1:0]  mode_b_q;
    reg [1:0]  mode_b_d;
    reg        upd_a_q;
    reg        upd_a_d;
    reg        upd_b_q;
    reg        upd_b_d;

    // Clock and data pass the same two-flop delay, so data stays aligned with its edge.
    // The serial clock is only sampled, so each of its phases must last at least two system clocks.
    wire        fall     = sclk_prev_q & ~sclk_s;
    wire        take     = fall & ~sync_n_s & armed_q;
    wire [23:0] frame    = {shift_q[22:0], sdin_s};
    wire        complete = take & (count_q == (`DDSL_FRAME_BITS - 5'h01));
    wire        f_load_b = frame[`DDSL_BIT_LOAD_B];
    wire        f_load_a = frame[`DDSL_BIT_LOAD_A];
    wire        f_sel_b  = frame[`DDSL_BIT_BUF_SEL];
    wire [1:0]  f_pd     = frame[`DDSL_PD_HI:`DDSL_PD_LO];
    wire [15:0] f_data   = frame[`DDSL_DATA_HI:`DDSL_DATA_LO];
    wire        wr_a     = complete & ~f_sel_b;
    wire        wr_b     = complete & f_sel_b;

    // Receiver: restarts whenever frame-select is high and counts taken bits while it is low.
    always @* begin
        shift_d = shift_q;
        count_d = count_q;
        armed_d = armed_q;
        done_d  = 1'h0;
        if (sync_n_s) begin
            // A rise before the 24th edge throws the partial frame away with no side effect.
            shift_d = `DDSL_SHIFT_RESET;
            count_d = 5'h00;
            armed_d = 1'h1;
        end else if (take) begin
            shift_d = frame;
            count_d = count_q + 5'h01;
            if (complete) begin
                // Extra edges after completion are ignored until frame-select goes high again.
                armed_d = 1'h0;
                done_d  = 1'h1;
            end
        end
    end

    // Buffers: the addressed buffer takes data and code only when a frame completes.
    always @* begin
        buf_a_d = buf_a_q;
        buf_b_d = buf_b_q;
        bpd_a_d = bpd_a_q;
        bpd_b_d = bpd_b_q;
        if (wr_a) begin
            buf_a_d = f_data;
            bpd_a_d = f_pd;
        end
        if (wr_b) begin
            buf_b_d = f_data;
            bpd_b_d = f_pd;
        end
    end

    // Channel A: a load reads the buffer as this frame leaves it, so a frame can write and load at once.
    always @* begin
        dac_a_d  = dac_a_q;
        mode_a_d = mode_a_q;
        upd_a_d  = 1'h0;
        if (complete & f_load_a) begin
            mode_a_d = bpd_a_d;
            upd_a_d  = 1'h1;
            // A power-down code keeps the last DAC value; only the mode changes.
            if (bpd_a_d == `DDSL_PD_NORMAL) begin
                dac_a_d = buf_a_d;
            end
        end
    end

    // Channel B: shares the completion strobe with channel A, so a dual load lands in one cycle.
    always @* begin
        dac_b_d  = dac_b_q;
        mode_b_d = mode_b_q;
        upd_b_d  = 1'h0;
        if (complete & f_load_b) begin
            mode_b_d = bpd_b_d;
            upd_b_d  = 1'h1;
            if (bpd_b_d == `DDSL_PD_NORMAL) begin
                dac_b_d = buf_b_d;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            sclk_prev_q <= 1'h0;
            shift_q     <= `DDSL_SHIFT_RESET;
            count_q     <= 5'h00;
            armed_q     <= 1'h0;
            done_q      <= 1'h0;
            buf_a_q     <= `DDSL_DATA_RESET;
            buf_b_q     <= `DDSL_DATA_RESET;
            bpd_a_q     <= `DDSL_PD_NORMAL;
            bpd_b_q     <= `DDSL_PD_NORMAL;
            dac_a_q     <= `DDSL_DATA_RESET;
            dac_b_q     <= `DDSL_DATA_RESET;
            mode_a_q    <= `DDSL_PD_NORMAL;
            mode_b_q    <= `DDSL_PD_NORMAL;
            upd_a_q     <= 1'h0;
            upd_b_q     <= 1'h0;
        end else begin
            sclk_prev_q <= sclk_s;
            shift_q     <= shift_d;
            count_q     <= count_d;
            armed_q     <= armed_d;
            done_q      <= done_d;
            buf_a_q     <= buf_a_d;
            buf_b_q     <= buf_b_d;
            bpd_a_q     <= bpd_a_d;
            bpd_b_q     <= bpd_b_d;
            dac_a_q     <= dac_a_d;
            dac_b_q     <= dac_b_d;
            mode_a_q    <= mode_a_d;
            mode_b_q    <= mode_b_d;
            upd_a_q     <= upd_a_d;
            upd_b_q     <= upd_b_d;
        end
    end

    assign o_dac_a      = dac_a_q;
    assign o_dac_b      = dac_b_q;
    assign o_mode_a     = mode_a_q;
    assign o_mode_b     = mode_b_q;
    assign o_update_a   = upd_a_q;
    assign o_update_b   = upd_b_q;
    assign o_frame_done = done_q;
endmodule
`default_nettype wire

// ---- ddsl_core_chk.sv ----
// Assertions on the ports of the dual DAC load control.
`timescale 1ns/100ps
`default_nettype none
module ddsl_core_chk (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_sync_n,
    input wire logic        i_sclk,
    input wire logic        i_sdin,
    input wire logic [15:0] o_dac_a,
    input wire logic [15:0] o_dac_b,
    input wire logic [1:0]  o_mode_a,
    input wire logic [1:0]  o_mode_b,
    input wire logic        o_update_a,
    input wire logic        o_update_b,
    input wire logic        o_frame_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    upd_a_done_a: assert property (o_update_a |-> o_frame_done) else $error("load A alone");
    upd_b_done_a: assert property (o_update_b |-> o_frame_done) else $error("load B alone");
    done_pulse_a: assert property (o_frame_done |=> !o_frame_done) else $error("long done");
    dac_a_hold_a: assert property (o_dac_a != $past(o_dac_a) |-> o_update_a) else $error("dac A");
    dac_b_hold_a: assert property (o_dac_b != $past(o_dac_b) |-> o_update_b) else $error("dac B");
    mode_a_hold_a: assert property (o_mode_a != $past(o_mode_a) |-> o_update_a) else $error("mode A");
    mode_b_hold_a: assert property (o_mode_b != $past(o_mode_b) |-> o_update_b) else $error("mode B");
    pd_keep_dac_a: assert property (o_update_a && o_mode_a != 2'h0 |-> $stable(o_dac_a)) else $error("pd");
    cover property (o_update_a && o_update_b);
    cover property (o_update_a && !o_update_b);
    cover property (o_update_a && o_mode_a == 2'h3);
    cover property (o_frame_done && !o_update_a && !o_update_b);
endmodule
bind ddsl_core ddsl_core_chk chk_u (.*);
`default_nettype wire

// ---- ddsl_host.sv ----
// Host serial master model for the frame pins.
`timescale 1ns/100ps
`default_nettype none
module ddsl_host (
    input  wire logic i_clk,
    output var logic  o_sync_n,
    output var logic  o_sclk,
    output var logic  o_sdin
);
    initial {o_sync_n, o_sclk, o_sdin} = 3'h4;
    task automatic q(input int n);
        repeat (n) @(posedge i_clk) #1;
    endtask
    // Mode 0 is an SPI master: clock idles low and data moves on the rise, so it is steady at each fall.
    // Mode 1 is a byte-wide three-wire master: data moves just after each fall, with gaps between bytes.
    // Mode 2 addresses another device on the shared port, so this device's select stays high.
    task automatic send(input logic [23:0] f, input int n, input int m);
        o_sync_n = (m == 2);
        o_sdin   = f[23];
        q(4);
        for (int i = 23; i > 23 - n; i--) begin
            o_sclk = 1'h1;
            if (m != 1) o_sdin = f[i];
            q(4);
            o_sclk = 1'h0;
            q(2);
            if (m == 1 && i > 0) o_sdin = f[i - 1];
            q(2);
            if (m == 1 && i % 8 == 0) q(8);
        end
        o_sdin = ~o_sdin;
        q(4);
        o_sync_n = 1'h1;
        q(8);
    endtask
endmodule
`default_nettype wire

// ---- ddsl_map.vh ----
// Frame layout, power-down codes and reset values for the dual DAC serial load control.
`ifndef DDSL_MAP_VH
`define DDSL_MAP_VH
`define DDSL_FRAME_BITS    5'h18
`define DDSL_BIT_LOAD_B    21
`define DDSL_BIT_LOAD_A    20
`define DDSL_BIT_BUF_SEL   18
`define DDSL_PD_HI         17
`define DDSL_PD_LO         16
`define DDSL_DATA_HI       15
`define DDSL_DATA_LO       0
`define DDSL_PD_NORMAL     2'h0
`define DDSL_PD_1K         2'h1
`define DDSL_PD_100K       2'h2
`define DDSL_PD_HIZ        2'h3
`define DDSL_DATA_RESET    16'h0000
`define DDSL_SHIFT_RESET   24'h000000
`define DDSL_SYNC_RESET    2'h0
`endif

// ---- ddsl_sync.v ----
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module ddsl_sync #(
    parameter [0:0] RESET_VAL = 1'b0
) (
    input  wire i_clk,
    input  wire i_reset,
    input  wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;

    always @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// ---- dual_dac_serial_load_control_tb.sv ----
// Self-checking bench for the dual DAC load control.
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_load_control_tb;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    wire         sn, sc, sd, ua, ub, dn;
    wire  [15:0] da, db;
    wire  [1:0]  ma, mb;
    logic [15:0] bd [2] = '{16'h0000, 16'h0000};
    logic [15:0] ed [2] = '{16'h0000, 16'h0000};
    logic [1:0]  bm [2] = '{2'h0, 2'h0};
    logic [1:0]  em [2] = '{2'h0, 2'h0};
    logic [31:0] rng = 32'h2254;
    logic [31:0] r;
    int          fail_count = 0, comparisons = 0, cyc = 0, frames = 0, seen = 0;
    int          up_exp [2] = '{0, 0};
    int          up_seen [2] = '{0, 0};
    always #25 i_clk = ~i_clk;
    ddsl_host host_u (.i_clk(i_clk), .o_sync_n(sn), .o_sclk(sc), .o_sdin(sd));
    ddsl_core dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_sync_n(sn), .i_sclk(sc), .i_sdin(sd), .o_dac_a(da),
        .o_dac_b(db), .o_mode_a(ma), .o_mode_b(mb), .o_update_a(ua), .o_update_b(ub), .o_frame_done(dn));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Data bits of a power-down frame reach the buffer but never a DAC, so the model drops them.
    function automatic void model(input logic [23:0] f);
        if (f[17:16] == 2'h0) bd[f[18]] = f[15:0];
        bm[f[18]] = f[17:16];
        for (int c = 0; c < 2; c++) if (f[20 + c]) begin
            up_exp[c]++;
            em[c] = bm[c];
            if (bm[c] == 2'h0) ed[c] = bd[c];
        end
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(input logic [23:0] f, input int n, input int m);
        host_u.send(f, n, m);
        if (n == 24 && m != 2) begin
            model(f);
            frames++;
        end
        chk("dac_a", ed[0], da);
        chk("dac_b", ed[1], db);
        chk("modes", {12'h0, em[0], em[1]}, {12'h0, ma, mb});
        chk("frames", frames[15:0], seen[15:0]);
        chk("updates", {up_exp[1][7:0], up_exp[0][7:0]}, {up_seen[1][7:0], up_seen[0][7:0]});
        $display("frame test %h done", f);
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (dn === 1'b1) seen++;
        if (ua === 1'b1) up_seen[0]++;
        if (ub === 1'b1) up_seen[1]++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        #1 i_reset = 1'b0;
        repeat (4) @(posedge i_clk);
        chk("reset", 16'h0000, {12'h0, ma, mb} | da | db);
        run(24'h0012A5, 24, 0);
        run(24'h34C3F0, 24, 0);
        run(24'h105A5A, 24, 1);
        run(24'h24BEEF, 24, 0);
        run(24'h33FFFF, 24, 2);
        run(24'h30FFFF, 23, 0);
        run(24'h01FFFF, 24, 1);
        run(24'h360000, 24, 0);
        run(24'h131234, 24, 0);
        run(24'h27ABCD, 24, 1);
        run(24'h18C001, 24, 0);
        run(24'h24C002, 24, 1);
        repeat (12) begin
            r = xs();
            run({2'h0, r[21:0]}, 24, int'(r[31]));
        end
        finish_test();
    end
endmodule
`default_nettype wire
